// *** shared/crsq_defs.svh ***
// Clock and reset sequencer constants: offsets, fields, resets, timings.
// Assumes inclusion by bare name from the core module and the bench.
`ifndef CRSQ_DEFS_SVH
`define CRSQ_DEFS_SVH

// Register indexes and byte addresses (index times four)
`define CRSQ_IDX_MAIN_CLOCK_CONTROL 8'h38
`define CRSQ_IDX_RC_TRIM 8'h39
`define CRSQ_IDX_STATUS 8'h3a
`define CRSQ_ADDR_MAIN_CLOCK_CONTROL 10'h0e0
`define CRSQ_ADDR_RC_TRIM 10'h0e4
`define CRSQ_ADDR_STATUS 10'h0e8

// Field positions
`define CRSQ_BIT_SLOW_MODE 0
`define CRSQ_BIT_CLOCK_OUT 1
`define CRSQ_BIT_LOCK 0
`define CRSQ_BIT_IN_RESET 1

// Reset values
`define CRSQ_RST_MAIN_CLOCK_CONTROL 2'h0
`define CRSQ_RST_RC_TRIM 8'hff

// Timing
`define CRSQ_CLK_MHZ 100
`define CRSQ_SLOW_DIV 6'h20
`define CRSQ_DELAY_CYCLES 9'h100
`define CRSQ_FETCH_CYCLES 2'h2
`define CRSQ_VECTOR_LO 16'hfffe
`define CRSQ_VECTOR_HI 16'hffff
`define CRSQ_WDG_PULSE_NS 20000
`define CRSQ_PLL_STARTUP_US 1000

`endif

// *** shared/crsq_pkg.sv ***
// Types of the clock and reset sequencer.
// Needs nothing from the defs header.
package crsq_pkg;
    // Reset sequence phases
    typedef enum logic [2:0] {
        CRSQ_ACTIVE = 3'b000,
        CRSQ_DELAY = 3'b001,
        CRSQ_FETCH_LO = 3'b010,
        CRSQ_FETCH_HI = 3'b011,
        CRSQ_RUN = 3'b100
    } crsq_phase_t;
    // Oscillator source
    typedef enum logic [1:0] {
        CRSQ_SRC_EXT = 2'b00,
        CRSQ_SRC_RC = 2'b01,
        CRSQ_SRC_PLL4 = 2'b10,
        CRSQ_SRC_PLL8 = 2'b11
    } crsq_src_t;
endpackage : crsq_pkg

// *** core/crsq_sequencer.sv ***
// Clock and reset sequencer: source select, slow mode, trim, PLL start-up
// gate, lock flag and reset sequence, with a classic Wishbone slave.
// Assumes all inputs synchronous to ref_clk; the pin is open drain.
//
// Functional notes
// - PLL multiplies 1 MHz by 4 or 8
// - PLL off, RC on: osc is RC
// - Both off: osc is external clock
// - PLL withholds clock until start-up delay
// - Lock flag set when PLL at frequency
// - Clock-out enable drives main clock pin
// - Slow mode divides osc clock by 32
// - Trim resets to FFh, 00h fastest
// - Three sources; pin low during delay
// - Illegal opcode or prebyte also resets
// - 256 CPU cycle delay before fetch
// - Vector fetch lasts two cycles
// - Vector fetched from FFFEh and FFFFh
// - PLL clock after extra start-up delay
// - External reset detected without clock
// - Undervoltage drives reset pin low
// - Watchdog drives pin low minimum width
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "crsq_defs.svh"

module crsq_sequencer #(
    parameter int PLL_STARTUP_CYCLES =
        `CRSQ_PLL_STARTUP_US * `CRSQ_CLK_MHZ, // PLL start-up, shortenable
    parameter int WDG_PULSE_CYCLES =
        (`CRSQ_WDG_PULSE_NS * `CRSQ_CLK_MHZ + 999) / 1000
) (
    input wire logic ref_clk,
    input wire logic srst,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Option bits
    input wire logic optRcEnable,
    input wire logic optPllEnable,
    input wire logic optPllTimes8,
    // Oscillator enables (one pulse per source tick)
    input wire logic rcTick,
    input wire logic extClockTick,
    // Reset sources; haltWake only restarts the PLL start-up
    input wire logic resetPinIn,
    input wire logic lowVoltageDetect,
    input wire logic watchdogUnderflow,
    input wire logic illegalOpcode,
    input wire logic haltWake,
    // Reset pin drive, open drain
    output logic resetPinOut,
    output logic resetPinOe,
    // Clock results
    output logic oscClockEn,
    output logic cpuClockEn,
    output logic mainClockOut,
    output logic mainClockOutEn,
    output logic [7:0] trimCode,
    output logic pllLockFlag,
    // Core reset and vector fetch
    output logic coreReset,
    output logic vectorFetch,
    output logic [15:0] vectorAddr
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic ack;                       // Bus answer
        logic [31:0] rdata;              // Bus read data
        logic slowMode;                  // Slow mode select
        logic clockOut;                  // Clock-out enable
        logic [7:0] trim;                // RC trim code
        crsq_pkg::crsq_phase_t phase;    // Reset phase
        logic [8:0] delayCnt;            // 256-cycle delay count
        logic [31:0] pulseCnt;           // Watchdog pin pulse count
        logic [31:0] pllCnt;             // PLL start-up count
        logic pllLock;                   // PLL lock flag
        logic [2:0] pllPhase;            // PLL multiplier ticks
        logic [4:0] slowCnt;             // Slow divider
        logic oscEn;                     // Oscillator tick
        logic cpuEn;                     // CPU tick
        logic clock_out_enable;                       // Main clock out level
        logic sync1;                     // Release synchroniser stage 1
        logic sync2;                     // Release synchroniser stage 2
        logic vecFetch;                  // Fetch strobe
        logic [15:0] vecAddr;            // Fetch address
    } crsq_state_t;

    crsq_state_t st;
    crsq_state_t next_st;

    // Any reset source active this cycle
    logic srcActive;
    // Selected oscillator source
    crsq_pkg::crsq_src_t src;
    // Base 1 MHz tick for the PLL input
    logic baseTick;
    // Bus access decode
    logic wbReq;

    // ------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------
    always_comb begin
        if (optPllEnable) begin
            src = optPllTimes8 ? crsq_pkg::CRSQ_SRC_PLL8
                               : crsq_pkg::CRSQ_SRC_PLL4;
        end else if (optRcEnable) begin
            src = crsq_pkg::CRSQ_SRC_RC;
        end else begin
            src = crsq_pkg::CRSQ_SRC_EXT;
        end
    end

    // PLL input is RC when enabled, else the external clock
    assign baseTick = optRcEnable ? rcTick : extClockTick;

    // Pin and illegal opcode sampled combinationally so a reset is
    // entered at once; no running divider is needed to catch it.
    // The pin reads low while we drive it ourselves, so it only counts
    // as an external source while our own pull-down is off.
    assign srcActive = (!resetPinIn && !resetPinOe) || lowVoltageDetect ||
                       watchdogUnderflow || illegalOpcode;

    assign wbReq = wb_cyc_i && wb_stb_i && !st.ack;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ack = wbReq;
        next_st.vecFetch = 1'b0;
        // Register writes honour the low byte lane
        if (wbReq && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `CRSQ_ADDR_MAIN_CLOCK_CONTROL) begin
                // Upper bits are reserved and not stored
                next_st.slowMode = wb_dat_i[`CRSQ_BIT_SLOW_MODE];
                next_st.clockOut = wb_dat_i[`CRSQ_BIT_CLOCK_OUT];
            end else if (wb_adr_i == `CRSQ_ADDR_RC_TRIM) begin
                next_st.trim = wb_dat_i[7:0];
            end
        end
        // Register reads; unmapped reads answer zero
        next_st.rdata = 32'h0;
        if (wbReq && !wb_we_i) begin
            case (wb_adr_i)
                `CRSQ_ADDR_MAIN_CLOCK_CONTROL: begin
                    next_st.rdata[`CRSQ_BIT_CLOCK_OUT] = st.clockOut;
                    next_st.rdata[`CRSQ_BIT_SLOW_MODE] = st.slowMode;
                end
                `CRSQ_ADDR_RC_TRIM: begin
                    next_st.rdata[7:0] = st.trim;
                end
                `CRSQ_ADDR_STATUS: begin
                    next_st.rdata[`CRSQ_BIT_LOCK] = st.pllLock;
                    next_st.rdata[`CRSQ_BIT_IN_RESET] =
                        (st.phase != crsq_pkg::CRSQ_RUN);
                end
                default: begin
                    next_st.rdata = 32'h0;
                end
            endcase
        end

        // Oscillator tick: PLL gives 4 or 8 ticks per base period, as a
        // burst after each base tick; base period must be at least 8 cycles
        next_st.oscEn = 1'b0;
        case (src)
            crsq_pkg::CRSQ_SRC_EXT: next_st.oscEn = extClockTick;
            crsq_pkg::CRSQ_SRC_RC: next_st.oscEn = rcTick;
            default: begin
                // PLL withholds its output until start-up ends
                if (st.pllLock) begin
                    if (baseTick) begin
                        // Ticks still owed after this one
                        next_st.pllPhase =
                            (src == crsq_pkg::CRSQ_SRC_PLL8) ? 3'h7 : 3'h3;
                        next_st.oscEn = 1'b1;
                    end else if (st.pllPhase != 3'h0) begin
                        next_st.pllPhase = st.pllPhase - 3'h1;
                        next_st.oscEn = 1'b1;
                    end
                end
            end
        endcase

        // PLL start-up counter and lock flag
        if (st.pllCnt != 32'h0) begin
            next_st.pllCnt = st.pllCnt - 32'h1;
        end else if (optPllEnable) begin
            next_st.pllLock = 1'b1;
        end
        if (haltWake) begin
            // Restart after halt wake: lock lost again
            next_st.pllCnt = 32'(PLL_STARTUP_CYCLES);
            next_st.pllLock = 1'b0;
        end

        // Slow mode divider on the oscillator tick
        next_st.cpuEn = 1'b0;
        if (st.oscEn) begin
            next_st.slowCnt = st.slowCnt + 5'h1;
            if (!st.slowMode) begin
                next_st.cpuEn = 1'b1;
            end else if (st.slowCnt == 5'(`CRSQ_SLOW_DIV - 6'h1)) begin
                next_st.cpuEn = 1'b1;
                next_st.slowCnt = 5'h0;
            end
            next_st.clock_out_enable = !st.clock_out_enable;
        end

        // Release synchroniser: held while a source is active
        next_st.sync1 = !srcActive;
        next_st.sync2 = st.sync1;

        // Watchdog pin pulse stretch
        if (watchdogUnderflow) begin
            next_st.pulseCnt = 32'(WDG_PULSE_CYCLES);
        end else if (st.pulseCnt != 32'h0) begin
            next_st.pulseCnt = st.pulseCnt - 32'h1;
        end

        // Reset sequence
        case (st.phase)
            crsq_pkg::CRSQ_ACTIVE: begin
                next_st.delayCnt = 9'h0;
                if (st.sync2 && st.pulseCnt == 32'h0) begin
                    next_st.phase = crsq_pkg::CRSQ_DELAY;
                end
            end
            crsq_pkg::CRSQ_DELAY: begin
                if (st.cpuEn) begin
                    next_st.delayCnt = st.delayCnt + 9'h1;
                end
                if (st.delayCnt == `CRSQ_DELAY_CYCLES) begin
                    next_st.phase = crsq_pkg::CRSQ_FETCH_LO;
                end
            end
            crsq_pkg::CRSQ_FETCH_LO: begin
                next_st.vecFetch = 1'b1;
                next_st.vecAddr = `CRSQ_VECTOR_LO;
                next_st.phase = crsq_pkg::CRSQ_FETCH_HI;
            end
            crsq_pkg::CRSQ_FETCH_HI: begin
                next_st.vecFetch = 1'b1;
                next_st.vecAddr = `CRSQ_VECTOR_HI;
                next_st.phase = crsq_pkg::CRSQ_RUN;
            end
            crsq_pkg::CRSQ_RUN: begin
                next_st.phase = crsq_pkg::CRSQ_RUN;
            end
            default: begin
                next_st.phase = crsq_pkg::CRSQ_ACTIVE;
            end
        endcase

        // Any source restarts the sequence and resets registers
        if (srcActive) begin
            next_st.phase = crsq_pkg::CRSQ_ACTIVE;
            next_st.slowMode = 1'b0;
            next_st.clockOut = 1'b0;
            next_st.trim = `CRSQ_RST_RC_TRIM;
            next_st.pllCnt = 32'(PLL_STARTUP_CYCLES);
            next_st.pllLock = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Synchronous reset loads constants only
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '0;
            st.phase <= crsq_pkg::CRSQ_ACTIVE;
            st.trim <= `CRSQ_RST_RC_TRIM;
            st.pllCnt <= 32'(PLL_STARTUP_CYCLES);
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    // Pin low through the delay phase, undervoltage and watchdog stretch;
    // left free in the active phase so an external hold stays visible
    assign resetPinOe = (st.phase == crsq_pkg::CRSQ_DELAY) ||
                        lowVoltageDetect ||
                        (st.pulseCnt != 32'h0);
    assign resetPinOut = 1'b0;
    assign oscClockEn = st.oscEn;
    assign cpuClockEn = st.cpuEn;
    assign mainClockOut = st.clock_out_enable & st.clockOut;
    assign mainClockOutEn = st.clockOut;
    assign trimCode = st.trim;
    assign pllLockFlag = st.pllLock;
    assign coreReset = (st.phase != crsq_pkg::CRSQ_RUN);
    assign vectorFetch = st.vecFetch;
    assign vectorAddr = st.vecAddr;

endmodule : crsq_sequencer

// *** dv/crsq_sequencer_properties.sv ***
// Checker of the sequencer ports: bus answer, reset pin, fetch, lock.
// Assumes a bind onto the core; one clock, synchronous reset.
`timescale 1ns/1ns

module crsq_sequencer_props (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic wb_ack_o,
    input wire logic resetPinIn,
    input wire logic lowVoltageDetect,
    input wire logic watchdogUnderflow,
    input wire logic illegalOpcode,
    input wire logic haltWake,
    input wire logic optPllEnable,
    input wire logic resetPinOut,
    input wire logic resetPinOe,
    input wire logic pllLockFlag,
    input wire logic coreReset,
    input wire logic vectorFetch,
    input wire logic [15:0] vectorAddr
);
    // ----
    // Port relations
    // ----
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Ack is one pulse, answering each taken request next cycle
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_ack_on_take: assert property
        (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered");
    chk_lvd_pin_low: assert property (
        lowVoltageDetect |-> resetPinOe && !resetPinOut)
        else $error("undervoltage left pin free");
    chk_wdg_pin_low: assert property (
        watchdogUnderflow |=> resetPinOe [*4])
        else $error("watchdog pin pulse short");
    chk_fetch_pin_low: assert property (
        $rose(vectorFetch) |-> $past(resetPinOe, 2))
        else $error("pin free before fetch");
    chk_vector_pair: assert property (
        $rose(vectorFetch) |-> vectorAddr == 16'hfffe ##1
        vectorFetch && vectorAddr == 16'hffff ##1 !vectorFetch)
        else $error("vector fetch wrong");
    chk_illegal_reset: assert property (
        illegalOpcode |-> ##[0:2] coreReset)
        else $error("illegal opcode ignored");
    chk_pin_detect: assert property (
        !resetPinIn |-> ##[0:2] coreReset)
        else $error("pin reset ignored");
    chk_wake_lock_clear: assert property (
        haltWake && optPllEnable |=> !pllLockFlag [*2])
        else $error("lock kept over restart");
    cov_write: cover property (wb_ack_o && wb_we_i);
    cov_fetch: cover property ($rose(vectorFetch));
    cov_lock: cover property ($rose(pllLockFlag));
endmodule : crsq_sequencer_props

// *** dv/crsq_reset_circuit.sv ***
// External reset circuit: pulls the open-drain pin low on demand.
// Assumes a pull-up; the bench merges every pulldown on the wire.
`timescale 1ns/1ns

module crsq_reset_circuit #(
    parameter int MIN_PULSE = 2 // Shortest pulse it ever gives
) (
    input wire logic ref_clk,
    input wire logic pulseGo,
    input wire logic [7:0] pulseLen,
    output logic pullLow
);
    int remain = 0; // Cycles left holding the pin low
    // Never shorter than the minimum, however short the request
    always @(posedge ref_clk) begin
        if (pulseGo) begin
            remain <= (pulseLen < MIN_PULSE) ? MIN_PULSE : pulseLen;
        end else if (remain > 0) begin
            remain <= remain - 1;
        end
    end
    assign pullLow = (remain > 0); // Released: the pull-up wins
endmodule : crsq_reset_circuit

// *** dv/tb_clock_and_reset_sequencer.sv ***
// Bench of the clock and reset sequencer: bus, clocks, reset sources.
// Assumes the defs header on the path; source ticks are shortened.
`timescale 1ns/1ns
`include "crsq_defs.svh"

module tb_clock_and_reset_sequencer;
    localparam int TICK = 16; // RC tick period, shortened for run time
    localparam int XTICK = 24; // External tick, slower to tell apart
    localparam logic [9:0] CTL = `CRSQ_ADDR_MAIN_CLOCK_CONTROL;
    localparam logic [9:0] TRM = `CRSQ_ADDR_RC_TRIM;
    localparam logic [9:0] STS = `CRSQ_ADDR_STATUS;
    logic ref_clk = 1'b0, srst = 1'b1, wbCyc = 1'b0, wbStb = 1'b0;
    logic wbWe = 1'b0, rcOn = 1'b1, pllOn = 1'b0, pllX8 = 1'b0;
    logic rcTick = 1'b0, extTick = 1'b0, low_voltage_detector = 1'b0, wdg = 1'b0;
    logic illegal = 1'b0, wake = 1'b0, pulseGo = 1'b0, wbAck, pinOe;
    logic pinOut, oscEn, cpuEn, clkOut, clkOutEn, lock, coreRst, fetch;
    logic extPull, pinLevel;
    logic [9:0] wbAdr = 10'h0;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatI = 32'h0, wbDatO;
    logic [15:0] vecAddr;
    logic [7:0] trim, pulseLen = 8'h0;
    int numErrors = 0, totalChecks = 0, tickCnt = 0;
    assign pinLevel = !(pinOe === 1'b1 || extPull === 1'b1); // Pull-up

    crsq_sequencer #(.PLL_STARTUP_CYCLES(20), .WDG_PULSE_CYCLES(4))
    i_crsq_sequencer (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .optRcEnable(rcOn), .optPllEnable(pllOn), .optPllTimes8(pllX8),
        .rcTick(rcTick), .extClockTick(extTick), .resetPinIn(pinLevel),
        .lowVoltageDetect(low_voltage_detector), .watchdogUnderflow(wdg),
        .illegalOpcode(illegal), .haltWake(wake), .resetPinOut(pinOut),
        .resetPinOe(pinOe), .oscClockEn(oscEn), .cpuClockEn(cpuEn),
        .mainClockOut(clkOut), .mainClockOutEn(clkOutEn), .trimCode(trim),
        .pllLockFlag(lock), .coreReset(coreRst), .vectorFetch(fetch),
        .vectorAddr(vecAddr));
    crsq_reset_circuit i_crsq_reset_circuit (.ref_clk(ref_clk),
        .pulseGo(pulseGo), .pulseLen(pulseLen), .pullLow(extPull));

    initial begin
        forever #5 ref_clk = ~ref_clk; // 100 MHz
    end
    // Source ticks, one pulse per shortened period
    always @(posedge ref_clk) begin
        tickCnt <= tickCnt + 1;
        rcTick <= (tickCnt % TICK == 0);
        extTick <= (tickCnt % XTICK == 0);
    end

    // ----
    // Expectations and bus tasks
    // ----
    function automatic int exp_gap(input logic rc, input logic slow);
        return (rc ? TICK : XTICK) * (slow ? int'(`CRSQ_SLOW_DIV) : 1);
    endfunction : exp_gap
    function automatic int exp_osc(input logic x8);
        return 160 / TICK * (x8 ? 8 : 4); // Ticks in a 160-cycle window
    endfunction : exp_osc
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask : check
    // One classic cycle; holds all until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [9:0] adr,
        input logic [3:0] sel, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDatI <= d;
        do @(posedge ref_clk); while (wbAck !== 1'b1 && ++n < 50);
        q = wbDatO;
        if (n >= 50) numErrors++;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge ref_clk);
    endtask : wb_xfer
    task automatic wr(input logic [9:0] adr, input logic [7:0] d);
        logic [31:0] q;
        wb_xfer(1'b1, adr, 4'h1, {24'h0, d}, q);
    endtask : wr
    task automatic rd_chk(input logic [9:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, adr, 4'hf, 32'h0, q);
        check(q, exp);
    endtask : rd_chk
    // Second gap between CPU ticks, so a mode change has settled
    task automatic cpu_gap(output int gap);
        gap = 0;
        do @(posedge ref_clk); while (cpuEn !== 1'b1 && ++gap < 2000);
        repeat (2) begin
            gap = 0;
            do @(posedge ref_clk); while (cpuEn !== 1'b1 && ++gap < 2000);
            gap++;
        end
    endtask : cpu_gap
    // Follows a reset sequence to run: delay ticks, pin, vector fetch
    task automatic wait_run();
        int n, cpu, pinOff;
        n = 0;
        cpu = 0;
        pinOff = 0;
        do begin
            @(posedge ref_clk);
            n++;
            if (cpu > 0 && cpu < 256 && pinOe !== 1'b1) pinOff++;
            if (cpuEn === 1'b1 && fetch !== 1'b1) cpu++;
        end while (fetch !== 1'b1 && n < 20000);
        check(vecAddr, 32'hfffe);
        @(posedge ref_clk);
        check({fetch, vecAddr}, 32'h1ffff);
        repeat (3) @(posedge ref_clk);
        check({fetch, coreRst}, 32'h0);
        check(pinOff, 0);
        check(32'(cpu >= 256 && cpu <= 257), 1);
    endtask : wait_run
    // Raises one reset source and returns once it has gone away
    task automatic fire(input int s);
        int n;
        n = 0;
        pulseGo <= (s == 0);
        pulseLen <= 8'($urandom_range(40, 1));
        low_voltage_detector <= (s == 1);
        wdg <= (s == 2);
        illegal <= (s == 3);
        repeat ((s == 1) ? 10 : 1) @(posedge ref_clk);
        if (s == 1) check(pinOe, 1);
        {pulseGo, low_voltage_detector, wdg, illegal} <= 4'h0;
        do @(posedge ref_clk); while (extPull === 1'b1 && ++n < 60);
    endtask : fire
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // ----
    // Main sequence
    // ----
    initial begin
        logic [31:0] q;
        logic [7:0] v;
        int gap, n, early, e;
        void'($urandom(32'h1bc0));
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        wait_run();
        rd_chk(CTL, 32'h0);
        rd_chk(TRM, 32'hff);
        rd_chk(10'h3fc, 32'h0); // Unmapped place reads zero
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'h80 : (i == 1) ? 8'h00 : 8'($urandom);
            wr(TRM, v);
            rd_chk(TRM, {24'h0, v});
        end
        wb_xfer(1'b1, TRM, 4'h0, 32'h5a, q);
        check(trim, v);
        for (int m = 0; m < 4; m++) begin
            wr(CTL, 8'(m));
            rd_chk(CTL, 32'(m));
            check(clkOutEn, m[1]);
            cpu_gap(gap);
            check(gap, exp_gap(1'b1, m[0]));
        end
        wr(CTL, 8'h0);
        rcOn <= 1'b0;
        cpu_gap(gap);
        check(gap, exp_gap(1'b0, 1'b0));
        rcOn <= 1'b1;
        for (int t = 0; t < 2; t++) begin
            pllX8 <= t[0];
            pllOn <= 1'b1;
            wake <= 1'b1;
            @(posedge ref_clk);
            wake <= 1'b0;
            n = 0;
            early = 0;
            repeat (2) @(posedge ref_clk);
            do begin
                @(posedge ref_clk);
                if (oscEn === 1'b1 && lock !== 1'b1) early++;
            end while (lock !== 1'b1 && ++n < 3000);
            check(early, 0);
            rd_chk(STS, 32'h1);
            n = 0;
            e = exp_osc(t[0]);
            repeat (160) begin
                @(posedge ref_clk);
                n += int'(oscEn === 1'b1);
            end
            check(32'(n >= e - 1 && n <= e + 1), 1);
        end
        pllOn <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            wr(CTL, 8'h3);
            fire(s);
            wait_run();
            rd_chk(CTL, 32'h0);
            rd_chk(TRM, 32'hff);
            wr(TRM, 8'($urandom));
        end
        tally_and_finish();
    end
    initial begin
        repeat (60000) @(posedge ref_clk);
        numErrors++;
        tally_and_finish();
    end
endmodule : tb_clock_and_reset_sequencer

bind crsq_sequencer crsq_sequencer_props i_props (
    .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .resetPinIn(resetPinIn), .lowVoltageDetect(lowVoltageDetect),
    .watchdogUnderflow(watchdogUnderflow), .illegalOpcode(illegalOpcode),
    .haltWake(haltWake), .optPllEnable(optPllEnable),
    .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .pllLockFlag(pllLockFlag), .coreReset(coreReset),
    .vectorFetch(vectorFetch), .vectorAddr(vectorAddr));
